// File: rtl/crtrac_refresh_ctrl.v
`default_nettype none
`include "crtrac_defines.vh"
module crtrac_refresh_ctrl (
  input wire clk,
  input wire srst,
  input wire regSel,
  input wire regWrite,
  input wire regRead,
  input wire addrWrite,
  input wire [7:0] wrData,
  input wire phase1,
  input wire charEn,
  input wire lightPenStrobe,
  output reg [7:0] rdData_q,
  output reg [13:0] refreshAddrOut_q,
  output reg [4:0] rasterAddr_q,
  output reg strobeOrRa4_q,
  output reg cursorOut_q,
  output reg hRetrace_q,
  output reg vRetrace_q
);
  // ----------------------------------------
  // Programming registers
  // ----------------------------------------
  reg [4:0] regIndex_q;
  reg [7:0] horizontalTotalCount_q;
  reg [6:0] verticalTotalRows_q;
  reg [4:0] verticalAdjust_q;
  reg [6:0] verticalShownRows_q;
  reg [7:0] modeControl_q;
  reg [4:0] rasterLinesPerRow_q;
  reg [6:0] cursorFirstLine_q;
  reg [4:0] cursorLastLine_q;
  reg [13:0] displayOrigin_q;
  reg [13:0] cursorLocation_q;
  reg [13:0] penCapture_q;
  reg [13:0] updatePointer_q;
  reg updateReady_q;
  reg updatePending_q;
  // Counters
  reg [7:0] charCount_q;
  reg [4:0] lineCount_q;
  reg [6:0] rowCount_q;
  reg [4:0] adjCount_q;
  reg inAdjust_q;
  reg [13:0] rowStart_q;
  reg [13:0] scanCounter_q;
  reg oddField_q;
  reg [4:0] fieldCount_q;
  reg cursorHit_q;
  reg [2:0] penSync_q;
  reg penLevel_q;
  wire writeReg = regSel & regWrite & ~addrWrite;
  wire penFall;
  wire lastChar;
  wire lastLine;
  wire lastRow;
  wire endFrame;
  wire blinkOn;
  wire curEnable;
  wire [4:0] rasterNow;
  wire retrace;
  wire ilaceVideo;
  wire doRetraceUpd;
  wire curMatch;
  // Row step and update decodes
  wire [13:0] rowNext;
  wire updHiWr;
  wire updLoWr;
  wire trigWr;
  wire updDone;

  // Start of the next character row. Binary form steps by the row length;
  // row/column form bumps the row byte and keeps the origin's column, so
  // the four address pairs and the pins share one layout
  function [13:0] nextRowStart;
    input [13:0] start;
    input rowCol;
    input [7:0] rowLen;
    begin
      nextRowStart = start + {6'h00, rowLen};
      if (rowCol) begin
        nextRowStart = {start[13:8] + 6'h01, start[7:0]};
      end
    end
  endfunction

  // One decode for the data writes that land on the update pointer and trigger slots
  function slotWrite;
    input sel;
    input [4:0] index;
    input [4:0] slot;
    begin
      slotWrite = sel && (index == slot);
    end
  endfunction

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Index register is written when addrWrite is set; data goes to the slot
  // Writes to unknown slots fall through the default and are lost
  always @(posedge clk) begin
    if (srst) begin
      regIndex_q <= 5'h00;
      horizontalTotalCount_q <= `CRTRAC_RST_HTOTAL;
      verticalTotalRows_q <= `CRTRAC_RST_VTOTAL;
      verticalAdjust_q <= 5'h00;
      verticalShownRows_q <= `CRTRAC_RST_VSHOWN;
      modeControl_q <= `CRTRAC_RST_MODE;
      rasterLinesPerRow_q <= `CRTRAC_RST_LINES;
      cursorFirstLine_q <= 7'h00;
      cursorLastLine_q <= 5'h00;
      displayOrigin_q <= 14'h0000;
      cursorLocation_q <= 14'h0000;
    end else if (regSel & regWrite & addrWrite) begin
      regIndex_q <= wrData[4:0];
    end else if (writeReg) begin
      case (regIndex_q)
        `CRTRAC_REG_HTOTAL: horizontalTotalCount_q <= wrData;
        `CRTRAC_REG_VTOTAL: verticalTotalRows_q <= wrData[6:0];
        `CRTRAC_REG_VADJ: verticalAdjust_q <= wrData[4:0];
        `CRTRAC_REG_VSHOWN: verticalShownRows_q <= wrData[6:0];
        `CRTRAC_REG_MODE: modeControl_q <= wrData;
        `CRTRAC_REG_LINES: rasterLinesPerRow_q <= wrData[4:0];
        `CRTRAC_REG_CURFIRST: cursorFirstLine_q <= wrData[6:0];
        `CRTRAC_REG_CURLAST: cursorLastLine_q <= wrData[4:0];
        `CRTRAC_REG_ORGHI: displayOrigin_q[13:8] <= wrData[5:0];
        `CRTRAC_REG_ORGLO: displayOrigin_q[7:0] <= wrData;
        `CRTRAC_REG_CURHI: cursorLocation_q[13:8] <= wrData[5:0];
        `CRTRAC_REG_CURLO: cursorLocation_q[7:0] <= wrData;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Status sits on the index address; unreadable slots return zero
  // Read data stands until the next read, so the host may take it late
  always @(posedge clk) begin
    if (srst) begin
      rdData_q <= 8'h00;
    end else if (regSel & regRead) begin
      rdData_q <= 8'h00;
      if (addrWrite) begin
        rdData_q[`CRTRAC_STAT_READY] <= updateReady_q;
      end else begin
        case (regIndex_q)
          `CRTRAC_REG_CURHI: rdData_q <= {2'h0, cursorLocation_q[13:8]};
          `CRTRAC_REG_CURLO: rdData_q <= cursorLocation_q[7:0];
          `CRTRAC_REG_PENHI: rdData_q <= {2'h0, penCapture_q[13:8]};
          `CRTRAC_REG_PENLO: rdData_q <= penCapture_q[7:0];
          default: rdData_q <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Character, line and row counters
  // ----------------------------------------
  assign ilaceVideo = modeControl_q[1:0] == `CRTRAC_ILACE_VIDEO;
  assign lastChar = charCount_q == horizontalTotalCount_q;
  assign lastLine = lineCount_q == rasterLinesPerRow_q;
  assign lastRow = rowCount_q == verticalTotalRows_q;
  assign endFrame = inAdjust_q ? (adjCount_q == verticalAdjust_q)
    : (lastRow && verticalAdjust_q == 5'h00);
  // Horizontal display end is a fixed count; the vertical end comes from the shown-rows register
  assign retrace = (charCount_q >= `CRTRAC_RST_HSHOWN) |
    (rowCount_q >= verticalShownRows_q) | inAdjust_q;
  // Interlace sync only flips the field; sync-and-video also splits lines
  // Sync-and-video shows odd lines in odd fields
  assign rasterNow = ilaceVideo ? {lineCount_q[3:0], oddField_q}
    : lineCount_q;
  // Row/column form keeps the row in the high byte of every address
  assign rowNext = nextRowStart(rowStart_q,
    modeControl_q[`CRTRAC_MODE_ROWCOL],
    horizontalTotalCount_q);

  // The scan counter steps once a character time and restarts each line
  // at its row start, so all lines of one row repeat one address run
  always @(posedge clk) begin
    if (srst) begin
      charCount_q <= 8'h00;
      lineCount_q <= 5'h00;
      rowCount_q <= 7'h00;
      adjCount_q <= 5'h00;
      inAdjust_q <= 1'b0;
      rowStart_q <= 14'h0000;
      scanCounter_q <= 14'h0000;
      oddField_q <= 1'b0;
      fieldCount_q <= 5'h00;
    end else if (charEn) begin
      charCount_q <= lastChar ? 8'h00 : charCount_q + 8'h01;
      scanCounter_q <= scanCounter_q + 14'h0001;
      if (lastChar) begin
        scanCounter_q <= rowStart_q;
        if (inAdjust_q | lastLine) begin
          lineCount_q <= 5'h00;
          if (endFrame) begin
            // New frame restarts at the display origin
            rowCount_q <= 7'h00;
            inAdjust_q <= 1'b0;
            adjCount_q <= 5'h00;
            rowStart_q <= displayOrigin_q;
            scanCounter_q <= displayOrigin_q;
            oddField_q <= ~oddField_q & (modeControl_q[0]);
            fieldCount_q <= fieldCount_q + 5'h01;
          end else if (inAdjust_q | lastRow) begin
            inAdjust_q <= 1'b1;
            adjCount_q <= adjCount_q + {4'h0, inAdjust_q};
          end else begin
            rowCount_q <= rowCount_q + 7'h01;
            rowStart_q <= rowNext;
            scanCounter_q <= rowNext;
          end
        end else begin
          lineCount_q <= lineCount_q + 5'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Cursor
  // ----------------------------------------
  // Suppressed mode overrides match and range; blink rates count fields
  assign curMatch = scanCounter_q == cursorLocation_q;
  assign blinkOn = cursorFirstLine_q[6] ?
    (cursorFirstLine_q[5] ? fieldCount_q[4] : fieldCount_q[3])
    : ~cursorFirstLine_q[5];
  assign curEnable = curMatch && blinkOn &&
    (rasterNow >= cursorFirstLine_q[4:0]) &&
    (rasterNow <= cursorLastLine_q) && !retrace;

  // Delay path gives one extra character time when mode bit 5 is set
  // A delayed cursor lines up with a pipelined character generator
  always @(posedge clk) begin
    if (srst) begin
      cursorHit_q <= 1'b0;
      cursorOut_q <= 1'b0;
    end else if (charEn) begin
      cursorHit_q <= curEnable;
      cursorOut_q <= modeControl_q[`CRTRAC_MODE_CURDLY] ? cursorHit_q
        : curEnable;
    end
  end

  // ----------------------------------------
  // Light pen capture
  // ----------------------------------------
  // Three stages; a change counts when the last two agree
  // A low pulse shorter than two clocks never reaches the capture
  // The counter, not the pins, is captured so updates do not skew it
  assign penFall = penLevel_q & ~penSync_q[1] & ~penSync_q[2];
  always @(posedge clk) begin
    if (srst) begin
      penSync_q <= 3'h7;
      penLevel_q <= 1'b1;
      penCapture_q <= 14'h0000;
    end else begin
      penSync_q <= {penSync_q[1:0], lightPenStrobe};
      if (penSync_q[1] == penSync_q[2]) begin
        penLevel_q <= penSync_q[2];
      end
      if (penFall) begin
        penCapture_q <= scanCounter_q;
      end
    end
  end

  // ----------------------------------------
  // Transparent update pointer
  // ----------------------------------------
  // Retrace updates wait for phase 2 so the processor side owns phase 1
  assign doRetraceUpd = updatePending_q & retrace & ~phase1 &
    ~modeControl_q[`CRTRAC_MODE_INTERLV];
  // Interleaved updates need no retrace: the next phase 1 carries them
  assign updDone = updatePending_q & (doRetraceUpd |
    (modeControl_q[`CRTRAC_MODE_INTERLV] & phase1));
  assign updHiWr = slotWrite(writeReg, regIndex_q, `CRTRAC_REG_UPDHI);
  assign updLoWr = slotWrite(writeReg, regIndex_q, `CRTRAC_REG_UPDLO);
  assign trigWr = slotWrite(writeReg, regIndex_q, `CRTRAC_REG_TRIGGER);

  // Pointer loads win over the step; the host reloads between transfers
  always @(posedge clk) begin
    if (srst) begin
      updatePointer_q <= 14'h0000;
      updatePending_q <= 1'b0;
      updateReady_q <= 1'b0;
    end else begin
      if (updHiWr) begin
        updatePointer_q[13:8] <= wrData[5:0];
      end else if (updLoWr) begin
        updatePointer_q[7:0] <= wrData;
      end else if (updDone) begin
        updatePointer_q <= updatePointer_q + 14'h0001;
      end
      // Completion wins over a trigger in the same cycle: a trigger while
      // one is still pending is lost, so the host polls ready first
      if (updDone) begin
        updatePending_q <= 1'b0;
        updateReady_q <= 1'b1;
      end else if (trigWr) begin
        updatePending_q <= 1'b1;
        updateReady_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Address and shared pin outputs
  // ----------------------------------------
  // Every pin is registered; the mux works on settled state, so a
  // pointer load shows on the pins one cycle later
  always @(posedge clk) begin
    if (srst) begin
      refreshAddrOut_q <= 14'h0000;
      rasterAddr_q <= 5'h00;
      strobeOrRa4_q <= 1'b0;
      hRetrace_q <= 1'b0;
      vRetrace_q <= 1'b0;
    end else begin
      rasterAddr_q <= rasterNow;
      hRetrace_q <= charCount_q >= `CRTRAC_RST_HSHOWN;
      vRetrace_q <= (rowCount_q >= verticalShownRows_q) | inAdjust_q;
      refreshAddrOut_q <= scanCounter_q;
      if (modeControl_q[`CRTRAC_MODE_TRANSP]) begin
        if (modeControl_q[`CRTRAC_MODE_INTERLV] & phase1) begin
          refreshAddrOut_q <= updatePointer_q;
        end else if (doRetraceUpd) begin
          refreshAddrOut_q <= updatePointer_q;
        end
      end
      if (!modeControl_q[`CRTRAC_MODE_STROBE]) begin
        strobeOrRa4_q <= rasterNow[4];
      end else begin
        strobeOrRa4_q <= doRetraceUpd &
          modeControl_q[`CRTRAC_MODE_TRANSP];
      end
    end
  end
endmodule // crtrac_refresh_ctrl
`default_nettype wire

// File: rtl/crtrac_defines.vh
`ifndef CRTRAC_DEFINES_VH
`define CRTRAC_DEFINES_VH
// ----------------------------------------
// Register numbers
// ----------------------------------------
`define CRTRAC_REG_HTOTAL 5'h00
`define CRTRAC_REG_VTOTAL 5'h04
`define CRTRAC_REG_VADJ 5'h05
`define CRTRAC_REG_VSHOWN 5'h06
`define CRTRAC_REG_MODE 5'h08
`define CRTRAC_REG_LINES 5'h09
`define CRTRAC_REG_CURFIRST 5'h0A
`define CRTRAC_REG_CURLAST 5'h0B
`define CRTRAC_REG_ORGHI 5'h0C
`define CRTRAC_REG_ORGLO 5'h0D
`define CRTRAC_REG_CURHI 5'h0E
`define CRTRAC_REG_CURLO 5'h0F
`define CRTRAC_REG_PENHI 5'h10
`define CRTRAC_REG_PENLO 5'h11
`define CRTRAC_REG_UPDHI 5'h12
`define CRTRAC_REG_UPDLO 5'h13
`define CRTRAC_REG_TRIGGER 5'h1F
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CRTRAC_MODE_ILACE_LO 0
`define CRTRAC_MODE_ILACE_HI 1
`define CRTRAC_MODE_ROWCOL 2
`define CRTRAC_MODE_TRANSP 3
`define CRTRAC_MODE_CURDLY 5
`define CRTRAC_MODE_STROBE 6
`define CRTRAC_MODE_INTERLV 7
`define CRTRAC_STAT_READY 7
`define CRTRAC_ILACE_SYNC 2'h1
`define CRTRAC_ILACE_VIDEO 2'h3
`define CRTRAC_CUR_STEADY 2'h0
`define CRTRAC_CUR_OFF 2'h1
`define CRTRAC_CUR_BLINK16 2'h2
// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define CRTRAC_RST_MODE 8'h00
`define CRTRAC_RST_LINES 5'h0F
`define CRTRAC_RST_HTOTAL 8'h3F
`define CRTRAC_RST_HSHOWN 8'h28
`define CRTRAC_RST_VTOTAL 7'h1F
`define CRTRAC_RST_VSHOWN 7'h18
`define CRTRAC_BLINK16 5'h0F
`define CRTRAC_BLINK32 5'h1F
`endif

// File: dv/crtrac_checker_sva.sv
`default_nettype none
`include "crtrac_defines.vh"
module crtrac_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic regSel,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic addrWrite,
  input wire logic [7:0] wrData,
  input wire logic phase1,
  input wire logic charEn,
  input wire logic lightPenStrobe,
  input wire logic [7:0] rdData_q,
  input wire logic [13:0] refreshAddrOut_q,
  input wire logic [4:0] rasterAddr_q,
  input wire logic strobeOrRa4_q,
  input wire logic cursorOut_q,
  input wire logic hRetrace_q,
  input wire logic vRetrace_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] idxQ;
  logic [7:0] modeQ;
  logic [7:0] firstQ;
  logic [4:0] lastQ;
  logic [4:0] linesQ;
  logic [12:0] ageQ;
  logic [2:0] offQ;
  wire dataWr = regSel && regWrite && !addrWrite;
  // Setup shadow; age restarts on setup writes so settling is not judged
  always @(posedge clk) begin
    if (srst) begin
      idxQ <= 5'h00;
      modeQ <= `CRTRAC_RST_MODE;
      firstQ <= 8'h00;
      lastQ <= 5'h00;
      linesQ <= `CRTRAC_RST_LINES;
      ageQ <= 13'h0000;
      offQ <= 3'h0;
    end else begin
      if (regSel && regWrite && addrWrite) idxQ <= wrData[4:0];
      if (dataWr && idxQ == `CRTRAC_REG_MODE) modeQ <= wrData;
      if (dataWr && idxQ == `CRTRAC_REG_CURFIRST) firstQ <= wrData;
      if (dataWr && idxQ == `CRTRAC_REG_CURLAST) lastQ <= wrData[4:0];
      if (dataWr && idxQ == `CRTRAC_REG_LINES) linesQ <= wrData[4:0];
      if (dataWr && idxQ inside {`CRTRAC_REG_MODE, `CRTRAC_REG_LINES,
          `CRTRAC_REG_CURFIRST, `CRTRAC_REG_CURLAST}) ageQ <= 13'h0000;
      else if (!(&ageQ)) ageQ <= ageQ + 13'h0001;
      if (firstQ[6:5] != `CRTRAC_CUR_OFF) offQ <= 3'h0;
      else if (!(&offQ)) offQ <= offQ + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  property p_reset;
    $fell(srst) |-> refreshAddrOut_q == 14'h0000 && !cursorOut_q;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not cleared by reset");
  property p_ra4;
    !modeQ[6] && !$past(modeQ[6]) |-> strobeOrRa4_q == rasterAddr_q[4];
  endproperty
  a_ra4: assert property (p_ra4)
    else $error("shared pin is not raster bit 4");
  property p_strb_ret;
    ageQ > 13'd2 && modeQ[6] && !modeQ[7] && strobeOrRa4_q |->
      hRetrace_q || vRetrace_q || $past(hRetrace_q) || $past(vRetrace_q);
  endproperty
  a_strb_ret: assert property (p_strb_ret)
    else $error("update strobe outside retrace");
  property p_strb_one;
    ageQ > 13'd2 && modeQ[6] && !modeQ[7] && strobeOrRa4_q |=>
      !strobeOrRa4_q;
  endproperty
  a_strb_one: assert property (p_strb_one)
    else $error("update strobe longer than one cycle");
  property p_cur_off;
    offQ == 3'd7 |-> !cursorOut_q;
  endproperty
  a_cur_off: assert property (p_cur_off)
    else $error("cursor shown in suppressed mode");
  property p_cur_rng;
    cursorOut_q && ageQ > 13'd4 |->
      (rasterAddr_q >= firstQ[4:0] && rasterAddr_q <= lastQ) ||
      ($past(rasterAddr_q) >= firstQ[4:0] && $past(rasterAddr_q) <= lastQ);
  endproperty
  a_cur_rng: assert property (p_cur_rng)
    else $error("cursor outside its line range");
  property p_lines;
    ageQ == 13'h1FFF && modeQ[1:0] != `CRTRAC_ILACE_VIDEO |->
      rasterAddr_q <= linesQ;
  endproperty
  a_lines: assert property (p_lines)
    else $error("raster line beyond lines per row");
  property p_trig_rd;
    regSel && regRead && !addrWrite && idxQ == `CRTRAC_REG_TRIGGER |=>
      rdData_q == 8'h00;
  endproperty
  a_trig_rd: assert property (p_trig_rd)
    else $error("trigger slot returned data");
endmodule // crtrac_checker
bind crtrac_refresh_ctrl crtrac_checker i_chk (.clk, .srst, .regSel,
  .regWrite, .regRead, .addrWrite, .wrData, .phase1, .charEn,
  .lightPenStrobe, .rdData_q, .refreshAddrOut_q, .rasterAddr_q,
  .strobeOrRa4_q, .cursorOut_q, .hRetrace_q, .vRetrace_q);
`default_nettype wire

// File: dv/crtrac_host_model.sv
`default_nettype none
module crtrac_host_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic hold,
  input wire logic strobeMode,
  input wire logic [13:0] addr,
  input wire logic strobe,
  output logic phase1,
  output logic charEn,
  output logic [13:0] strobeAddr,
  output logic [7:0] strobeCnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // Outside timing: phases and character enable, stoppable to freeze scan
  // Update latch grabs the address whenever the strobe is seen with strobeMode set
  always @(posedge clk) begin
    if (srst) begin
      phase1 <= 1'b0;
      charEn <= 1'b0;
      strobeCnt <= 8'h00;
      strobeAddr <= 14'h0000;
    end else begin
      phase1 <= !phase1;
      charEn <= !phase1 && !hold;
      if (strobeMode && strobe) begin
        strobeCnt <= strobeCnt + 8'h01;
        strobeAddr <= addr;
      end
    end
  end
endmodule // crtrac_host_model
`default_nettype wire

// File: dv/testbench.sv
`default_nettype none
`include "crtrac_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin \
  nMismatch++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic regSel = 1'b0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic addrWrite = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic lightPenStrobe = 1'b1;
  logic hold = 1'b0;
  logic strobeMode = 1'b0;
  logic phase1, charEn, strobeOrRa4_q, cursorOut_q, hRetrace_q, vRetrace_q;
  logic [7:0] rdData_q, strobeCnt;
  logic [13:0] refreshAddrOut_q, strobeAddr;
  logic [4:0] rasterAddr_q;
  int nMismatch = 0;
  int checksDone = 0;
  logic [15:0] expQ[$];
  logic [15:0] e;
  logic [1:0] rdP = 2'h0;
  logic [4:0] wo[5] = '{`CRTRAC_REG_MODE, `CRTRAC_REG_ORGLO,
    `CRTRAC_REG_UPDLO, `CRTRAC_REG_TRIGGER, 5'h1A};
  logic [7:0] md[4] = '{8'h01, 8'h03, 8'h20, 8'h04};
  crtrac_refresh_ctrl i_dut (.clk, .srst, .regSel, .regWrite, .regRead,
    .addrWrite, .wrData, .phase1, .charEn, .lightPenStrobe, .rdData_q,
    .refreshAddrOut_q, .rasterAddr_q, .strobeOrRa4_q, .cursorOut_q,
    .hRetrace_q, .vRetrace_q);
  crtrac_host_model i_host (.clk, .srst, .hold, .strobeMode,
    .addr(refreshAddrOut_q), .strobe(strobeOrRa4_q), .phase1, .charEn,
    .strobeAddr, .strobeCnt);
  always #50 clk = ~clk;
  // ----------------------------------------
  // Register bus tasks and result watcher
  // ----------------------------------------
  task automatic wr(input logic [4:0] i, input logic [7:0] d);
    @(posedge clk);
    regSel <= 1'b1;
    regWrite <= 1'b1;
    addrWrite <= 1'b1;
    wrData <= {3'h0, i};
    @(posedge clk);
    addrWrite <= 1'b0;
    wrData <= d;
    @(posedge clk);
    regSel <= 1'b0;
    regWrite <= 1'b0;
  endtask
  // Status reads skip the index write; the note goes in with the request
  task automatic rd(input logic [4:0] i, input logic st,
      input logic [7:0] m, input logic [7:0] x);
    // Index-only write: a data write here would clobber the slot
    if (!st) begin
      @(posedge clk);
      regSel <= 1'b1;
      regWrite <= 1'b1;
      addrWrite <= 1'b1;
      wrData <= {3'h0, i};
    end
    @(posedge clk);
    regSel <= 1'b1;
    regWrite <= 1'b0;
    regRead <= 1'b1;
    addrWrite <= st;
    expQ.push_back({m, x});
    @(posedge clk);
    regSel <= 1'b0;
    regRead <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic lim(input int w);
    if (w >= 2000) begin
      nMismatch++;
      $display("MISMATCH wait exp done got timeout");
      stop_test();
    end
  endtask
  // Judged a cycle late on the falling edge: safe for either settling point
  always @(posedge clk) rdP <= {rdP[0], regSel && regRead};
  always @(negedge clk) begin
    if (rdP[1]) begin
      e = expQ.pop_front();
      `CHK("rdData", e[7:0], rdData_q & e[15:8])
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int w;
    int n;
    logic [13:0] p;
    void'($urandom(86));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    // Short frame of two rows of four lines; default total count is odd
    wr(`CRTRAC_REG_VTOTAL, 8'h01);
    wr(`CRTRAC_REG_VSHOWN, 8'h01);
    wr(`CRTRAC_REG_LINES, 8'h03);
    // Cursor lines 0 and 1 only, so the range check has lines to refuse
    wr(`CRTRAC_REG_CURLAST, 8'h01);
    // Each cursor mode, cursor parked on the frame origin
    for (int m = 0; m < 4; m++) begin
      wr(`CRTRAC_REG_CURFIRST, {1'b0, 2'(m), 5'h00});
      n = 0;
      repeat (1500) begin
        @(negedge clk);
        if (cursorOut_q === 1'b1) n++;
      end
      if (m < 2) `CHK("cursorSeen", m == 0, n != 0)
    end
    p = 14'($urandom);
    wr(`CRTRAC_REG_CURHI, {2'h0, p[13:8]});
    wr(`CRTRAC_REG_CURLO, p[7:0]);
    rd(`CRTRAC_REG_CURHI, 1'b0, 8'h3F, {2'h0, p[13:8]});
    rd(`CRTRAC_REG_CURLO, 1'b0, 8'hFF, p[7:0]);
    // Frozen scan: pins then name the pen position exactly
    hold <= 1'b1;
    repeat (6) @(posedge clk);
    p = refreshAddrOut_q;
    lightPenStrobe <= 1'b0;
    repeat (8) @(posedge clk);
    lightPenStrobe <= 1'b1;
    rd(`CRTRAC_REG_PENHI, 1'b0, 8'h3F, {2'h0, p[13:8]});
    rd(`CRTRAC_REG_PENLO, 1'b0, 8'hFF, p[7:0]);
    hold <= 1'b0;
    foreach (md[i]) begin
      wr(`CRTRAC_REG_MODE, md[i]);
      repeat (300) @(posedge clk);
    end
    // Row/column form: the second row starts one row byte up
    n = 0;
    for (w = 0; w < 2000 && n == 0; w++) begin
      @(negedge clk);
      if (refreshAddrOut_q === 14'h0100) n = 1;
    end
    lim(w);
    `CHK("rowColStart", 1, n)
    wr(5'h1A, 8'h5A);
    foreach (wo[i]) rd(wo[i], 1'b0, 8'hFF, 8'h00);
    // Retrace updates, each triggered early in a shown line
    p = 14'($urandom);
    wr(`CRTRAC_REG_UPDHI, {2'h0, p[13:8]});
    wr(`CRTRAC_REG_UPDLO, p[7:0]);
    wr(`CRTRAC_REG_MODE, 8'h48);
    strobeMode <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      for (w = 0; w < 2000 && hRetrace_q !== 1'b1; w++) @(posedge clk);
      lim(w);
      for (w = 0; w < 2000 && (hRetrace_q | vRetrace_q) !== 1'b0; w++)
        @(posedge clk);
      lim(w);
      n = int'(strobeCnt);
      wr(`CRTRAC_REG_TRIGGER, 8'h00);
      rd(5'h00, 1'b1, 8'h80, 8'h00);
      for (w = 0; w < 2000 && int'(strobeCnt) == n; w++) @(posedge clk);
      lim(w);
      `CHK("strobeAddr", p + 14'(k), strobeAddr)
      rd(5'h00, 1'b1, 8'h80, 8'h80);
    end
    strobeMode <= 1'b0;
    // Interleaved update: pointer seen on the pins within a few cycles
    wr(`CRTRAC_REG_MODE, 8'h88);
    p = 14'($urandom);
    wr(`CRTRAC_REG_UPDHI, {2'h0, p[13:8]});
    wr(`CRTRAC_REG_UPDLO, p[7:0]);
    wr(`CRTRAC_REG_TRIGGER, 8'h00);
    n = 0;
    repeat (8) begin
      @(negedge clk);
      if (refreshAddrOut_q === p) n = 1;
    end
    `CHK("ptrOnPins", 1, n)
    rd(5'h00, 1'b1, 8'h80, 8'h80);
    // The performed update has stepped the pointer on
    n = 0;
    repeat (8) begin
      @(negedge clk);
      if (refreshAddrOut_q === 14'(p + 14'h0001)) n = 1;
    end
    `CHK("ptrStep", 1, n)
    wr(`CRTRAC_REG_MODE, 8'h00);
    repeat (8400) @(posedge clk);
    stop_test();
  end
endmodule // testbench
`default_nettype wire
